// >>> rtl/lcd_port_defines.svh
/*
 * Constants of the panel host port: register offsets, strap codes,
 * serial header layout and field positions.
 * Assumes it is included by bare name from the rtl files.
 */
`ifndef LCD_PORT_DEFINES_SVH
`define LCD_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define REG_STATUS 8'h00
`define REG_CTRL 8'h04
`define REG_INDEX 8'h08
`define REG_CDATA 8'h0C
`define REG_RDIDX 8'h10
`define REG_RDCTL 8'h14
`define REG_PIXEL 8'h18
`define REG_PXCNT 8'h1C

`define CTRL_RESET 32'h0000_0001
`define CTRL_PX_EN 0
`define ST_WR_FLAG 4
`define ST_PX_FLAG 5
`define ST_RD_FLAG 6
`define ST_BAD_STRAP 7

// ----------------------------------------------------------------
// strap codes {im3, im2, im1, im0}
// ----------------------------------------------------------------
`define IM_P16 4'b0010
`define IM_P8 4'b0011
`define IM_SER 4'b010?
`define IM_P18 4'b1010
`define IM_P9 4'b1011

// ----------------------------------------------------------------
// serial header: {device code, id, index select, rw}, rw high means read
// ----------------------------------------------------------------
`define SER_DEV_CODE 5'h0E
`define SER_HDR_BITS 5'h08
`define SER_DATA_BITS 5'h10

`endif

// >>> rtl/lcd_port_pkg.sv
/*
 * Types shared by the panel host port modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lcd_port_pkg;
	typedef enum logic [2:0] {
		MODE_NONE,
		MODE_P16,
		MODE_P8,
		MODE_P18,
		MODE_P9,
		MODE_SER
	} bus_mode_t;

	typedef enum logic [1:0] {
		SER_HDR,
		SER_DATA,
		SER_SKIP
	} ser_state_t;
endpackage : lcd_port_pkg

// >>> rtl/serial_link.sv
/*
 * Clocked serial link of the panel host port: header with device code,
 * id, index select and rw, then 16-bit words in or one 16-bit word out, MSB first.
 * Assumes sclk_i and sdi_i are already synchronised to clk_i and that
 * enable_i falls when the frame ends.
 */
`timescale 1ns/1ps
`include "lcd_port_defines.svh"

module serial_link (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic id_i,
	input wire logic [15:0] rd_idx_i,
	input wire logic [15:0] rd_ctl_i,
	output logic wr_pulse_o,
	output logic wr_isel_o,
	output logic [15:0] wr_data_o,
	output logic rd_start_o,
	output logic sdo_o,
	output logic sdo_oe_o
);
	import lcd_port_pkg::*;

	ser_state_t state_q, state_d;
	logic sclk_q, sclk_d;
	logic [15:0] sh_q, sh_d;
	logic [4:0] cnt_q, cnt_d;
	logic isel_q, isel_d, rw_q, rw_d, sdo_q, sdo_d, wr_q, wr_d, rds_q, rds_d;
	logic rise, fall;

	assign rise = sclk_i & ~sclk_q;
	assign fall = ~sclk_i & sclk_q;

	always_comb begin
		state_d = state_q;
		sclk_d = sclk_i;
		sh_d = sh_q;
		cnt_d = cnt_q;
		isel_d = isel_q;
		rw_d = rw_q;
		sdo_d = sdo_q;
		wr_d = 1'b0;
		rds_d = 1'b0;
		if (!enable_i) begin
			state_d = SER_HDR;
			cnt_d = 5'h00;
		end else begin
			unique case (state_q)
				SER_HDR: begin
					if (rise) begin
						sh_d = {sh_q[14:0], sdi_i};
						cnt_d = cnt_q + 5'h01;
						if (cnt_q + 5'h01 == `SER_HDR_BITS) begin
							cnt_d = 5'h00;
							isel_d = sh_q[0];
							rw_d = sdi_i;
							if (sh_q[6:1] == {`SER_DEV_CODE, id_i}) begin
								state_d = SER_DATA;
								if (sdi_i) begin
									sh_d = sh_q[0] ? rd_ctl_i : rd_idx_i;
									rds_d = 1'b1;
								end
							end else begin
								state_d = SER_SKIP;
							end
						end
					end
				end
				SER_DATA: begin
					if (rw_q) begin
						if (fall) begin
							sdo_d = sh_q[15];
							sh_d = {sh_q[14:0], 1'b0};
						end
					end else if (rise) begin
						sh_d = {sh_q[14:0], sdi_i};
						cnt_d = cnt_q + 5'h01;
						if (cnt_q + 5'h01 == `SER_DATA_BITS) begin
							cnt_d = 5'h00;
							wr_d = 1'b1;
						end
					end
				end
				SER_SKIP: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= SER_HDR;
			sclk_q <= 1'b1;
			sh_q <= 16'h0000;
			cnt_q <= 5'h00;
			isel_q <= 1'b0;
			rw_q <= 1'b0;
			sdo_q <= 1'b0;
			wr_q <= 1'b0;
			rds_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sclk_q <= sclk_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			isel_q <= isel_d;
			rw_q <= rw_d;
			sdo_q <= sdo_d;
			wr_q <= wr_d;
			rds_q <= rds_d;
		end
	end

	assign wr_pulse_o = wr_q;
	assign wr_isel_o = isel_q;
	assign wr_data_o = sh_q;
	assign rd_start_o = rds_q;
	assign sdo_o = sdo_q;
	assign sdo_oe_o = enable_i & (state_q == SER_DATA) & rw_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_SER_SAMPLE: assert property (@(posedge clk_i) disable iff (rst_i)
		(enable_i && state_q == SER_HDR && rise && cnt_q == 5'h00)
		|=> sh_q[0] == $past(sdi_i))
		else $error("serial input not sampled on rising clock");
	AST_SER_SHIFT: assert property (@(posedge clk_i) disable iff (rst_i)
		(enable_i && state_q == SER_DATA && rw_q && fall)
		|=> sdo_o == $past(sh_q[15]))
		else $error("serial output not advanced on falling clock");
	AST_SER_ID: assert property (@(posedge clk_i) disable iff (rst_i)
		(enable_i && state_q == SER_HDR && rise && cnt_q == 5'h07
		&& sh_q[1] != id_i) |=> state_q == SER_SKIP)
		else $error("header with wrong id accepted");
endmodule : serial_link

// >>> rtl/lcd_host_port.sv
/*
 * Host port of a small panel driver: strap-selected 8/9/16/18-bit
 * strobe bus or clocked serial link, 18-bit RGB pixel port, and an
 * Avalon-MM register slave that shows what the host wrote and supplies
 * what the host reads.
 * Assumes every pin input is asynchronous to clk_i; the strobe pins
 * must stay in each level for at least three clk_i cycles.
 */
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "lcd_port_defines.svh"


module lcd_host_port (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic hardware_init_n_i,
	input wire logic hardware_init2_n_i,
	input wire logic [2:0] interface_mode_straps_i,
	input wire logic mode_or_code_strap_i,
	input wire logic select_n_i,
	input wire logic register_index_select_i,
	input wire logic store_strobe_n_i,
	input wire logic read_strobe_n_i,
	input wire logic [17:0] parallel_data_bus_i,
	output logic [17:0] parallel_data_bus_o,
	output logic [17:0] parallel_data_bus_oe_o,
	input wire logic [17:0] rgb_pixel_bus_i,
	input wire logic pixel_clock_i,
	input wire logic pixel_enable_i,
	input wire logic pixel_valid_i,
	input wire logic line_sync_n_i,
	input wire logic frame_sync_n_i,
	output logic graphics_memory_we_o,
	output logic [17:0] graphics_memory_wdata_o
);
	import lcd_port_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic bus_mode_t strap_mode(input logic [3:0] s);
		casez (s)
			`IM_P16: strap_mode = MODE_P16;
			`IM_P8: strap_mode = MODE_P8;
			`IM_SER: strap_mode = MODE_SER;
			`IM_P18: strap_mode = MODE_P18;
			`IM_P9: strap_mode = MODE_P9;
			default: strap_mode = MODE_NONE;
		endcase
	endfunction : strap_mode

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		be_merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				be_merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction : be_merge

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int SW = 18 + 18 + 3 + 1 + 2 + 4 + 5;
	logic [SW-1:0] pin_raw, meta_q, sync_q;
	assign pin_raw = {parallel_data_bus_i, rgb_pixel_bus_i, interface_mode_straps_i,
		mode_or_code_strap_i, hardware_init_n_i, hardware_init2_n_i,
		select_n_i, register_index_select_i, store_strobe_n_i, read_strobe_n_i,
		pixel_clock_i, pixel_enable_i, pixel_valid_i, line_sync_n_i, frame_sync_n_i};
	// no reset here: the straps must already be settled when reset lifts
	always_ff @(posedge clk_i) begin
		meta_q <= pin_raw;
		sync_q <= meta_q;
	end

	logic [17:0] db_s, px_s;
	logic [3:0] strap_s;
	logic init_s, init2_s, sel_n_s, isel_s, st_n_s, rd_n_s;
	logic pclk_s, pen_s, pvld_s, ls_n_s, fs_n_s;
	assign {db_s, px_s, strap_s, init_s, init2_s, sel_n_s, isel_s, st_n_s, rd_n_s,
		pclk_s, pen_s, pvld_s, ls_n_s, fs_n_s} = sync_q;

	logic core_rst;
	assign core_rst = rst_i | ~init_s | ~init2_s;

	// ------------------------------------------------------------
	// link state
	// ------------------------------------------------------------
	bus_mode_t mode_q, mode_d;
	logic boot_q, boot_d, id_q, id_d, st_n_q, st_n_d, rd_n_q, rd_n_d;
	logic pclk_q, pclk_d, ls_q, ls_d, fs_q, fs_d;
	logic wr_evt, wr_isel, rd_evt, is_par, is_ser, sel;
	logic [17:0] wr_word, par_word, dout_q, dout_d;
	logic ser_wr, ser_isel, ser_rds, ser_sdo, ser_oe;
	logic [15:0] ser_data;
	logic [31:0] rdidx_q, rdctl_q;

	assign is_par = (mode_q != MODE_NONE) && (mode_q != MODE_SER);
	assign is_ser = (mode_q == MODE_SER);
	assign sel = ~sel_n_s;

	always_comb begin
		unique case (mode_q)
			MODE_P16: par_word = {2'b00, db_s[17:10], db_s[8:1]};
			MODE_P8: par_word = {10'h000, db_s[17:10]};
			MODE_P9: par_word = {9'h000, db_s[17:9]};
			default: par_word = db_s;
		endcase
	end

	always_comb begin
		mode_d = mode_q;
		id_d = id_q;
		boot_d = 1'b0;
		st_n_d = st_n_s;
		rd_n_d = rd_n_s;
		pclk_d = pclk_s;
		ls_d = ls_n_s;
		fs_d = fs_n_s;
		// straps caught once, at the first cycle after reset release
		if (boot_q) begin
			mode_d = strap_mode(strap_s);
			id_d = strap_s[0];
		end
		// read word picked by index select
		unique case (mode_q)
			MODE_P16: dout_d = {rdctl_q[15:8], 1'b0, rdctl_q[7:0], 1'b0};
			MODE_P8: dout_d = {rdctl_q[7:0], 10'h000};
			MODE_P9: dout_d = {rdctl_q[8:0], 9'h000};
			default: dout_d = rdctl_q[17:0];
		endcase
		if (!isel_s) begin
			unique case (mode_q)
				MODE_P16: dout_d = {rdidx_q[15:8], 1'b0, rdidx_q[7:0], 1'b0};
				MODE_P8: dout_d = {rdidx_q[7:0], 10'h000};
				MODE_P9: dout_d = {rdidx_q[8:0], 9'h000};
				default: dout_d = rdidx_q[17:0];
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			mode_q <= MODE_NONE;
			id_q <= 1'b0;
			boot_q <= 1'b1;
			st_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			pclk_q <= 1'b0;
			ls_q <= 1'b1;
			fs_q <= 1'b1;
			dout_q <= 18'h00000;
		end else begin
			mode_q <= mode_d;
			id_q <= id_d;
			boot_q <= boot_d;
			st_n_q <= st_n_d;
			rd_n_q <= rd_n_d;
			pclk_q <= pclk_d;
			ls_q <= ls_d;
			fs_q <= fs_d;
			dout_q <= dout_d;
		end
	end

	// store strobe doubles as shift clock
	serial_link serial_link_i (
		.clk_i(clk_i),
		.rst_i(core_rst),
		.enable_i(is_ser & sel),
		.sclk_i(st_n_s),
		.sdi_i(db_s[0]),
		.id_i(id_q),
		.rd_idx_i(rdidx_q[15:0]),
		.rd_ctl_i(rdctl_q[15:0]),
		.wr_pulse_o(ser_wr),
		.wr_isel_o(ser_isel),
		.wr_data_o(ser_data),
		.rd_start_o(ser_rds),
		.sdo_o(ser_sdo),
		.sdo_oe_o(ser_oe)
	);

	// capture at the strobe's closing edge
	assign wr_evt = (is_par & sel & st_n_s & ~st_n_q) | ser_wr;
	assign wr_isel = is_ser ? ser_isel : isel_s;
	assign wr_word = is_ser ? {2'b00, ser_data} : par_word;
	assign rd_evt = (is_par & sel & ~rd_n_s & rd_n_q) | ser_rds;

	// drive while read strobe low; serial uses line 1 only
	always_comb begin
		parallel_data_bus_o = dout_q;
		parallel_data_bus_oe_o = (is_par & sel & ~rd_n_s) ? 18'h3FFFF : 18'h00000;
		if (is_ser) begin
			parallel_data_bus_o = {16'h0000, ser_sdo, 1'b0};
			parallel_data_bus_oe_o = {16'h0000, ser_oe, 1'b0};
		end
	end

	// ------------------------------------------------------------
	// pixel port
	// ------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d, idx_q, idx_d, cdata_q, cdata_d, rdidx_d, rdctl_d;
	logic [17:0] pix_q, pix_d;
	logic [15:0] col_q, col_d, line_q, line_d;
	logic gwe_q, gwe_d, px_take;

	// one word per pixel clock rise
	assign px_take = pclk_s & ~pclk_q & pen_s & pvld_s & ctrl_q[`CTRL_PX_EN];

	always_comb begin
		pix_d = pix_q;
		col_d = col_q;
		line_d = line_q;
		gwe_d = px_take;
		if (px_take) begin
			pix_d = px_s;
			col_d = col_q + 16'h0001;
		end
		if (!ls_n_s && ls_q) begin
			col_d = 16'h0000;
			line_d = line_q + 16'h0001;
		end
		if (!fs_n_s && fs_q) begin
			line_d = 16'h0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			pix_q <= 18'h00000;
			col_q <= 16'h0000;
			line_q <= 16'h0000;
			gwe_q <= 1'b0;
		end else begin
			pix_q <= pix_d;
			col_q <= col_d;
			line_q <= line_d;
			gwe_q <= gwe_d;
		end
	end

	assign graphics_memory_we_o = gwe_q;
	assign graphics_memory_wdata_o = pix_q;

	// ------------------------------------------------------------
	// register slave
	// ------------------------------------------------------------
	logic [2:0] flag_q, flag_d;
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic req, wr_go;

	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_q;
	// a write commits only at the edge that ends the wait state
	assign wr_go = avs_write_i & ack_q;

	always_comb begin
		ack_d = req & ~ack_q;
		ctrl_d = ctrl_q;
		rdidx_d = rdidx_q;
		rdctl_d = rdctl_q;
		idx_d = idx_q;
		cdata_d = cdata_q;
		flag_d = flag_q;
		rdata_d = rdata_q;
		if (wr_go) begin
			unique case (avs_address_i)
				`REG_CTRL: ctrl_d = be_merge(ctrl_q, avs_writedata_i, avs_byteenable_i);
				`REG_RDIDX: rdidx_d = be_merge(rdidx_q, avs_writedata_i, avs_byteenable_i);
				`REG_RDCTL: rdctl_d = be_merge(rdctl_q, avs_writedata_i, avs_byteenable_i);
				`REG_STATUS: begin
					if (avs_byteenable_i[0]) begin
						flag_d = flag_q & ~avs_writedata_i[`ST_RD_FLAG:`ST_WR_FLAG];
					end
				end
				default: begin
				end
			endcase
		end
		// hardware set wins over a same-cycle clear
		flag_d = flag_d | {rd_evt, gwe_q, wr_evt};
		if (wr_evt) begin
			if (wr_isel) begin
				cdata_d = {14'h0000, wr_word};
			end else begin
				idx_d = {14'h0000, wr_word};
			end
		end
		if (avs_read_i & ~ack_q) begin
			unique case (avs_address_i)
				`REG_STATUS: rdata_d = {24'h000000, mode_q == MODE_NONE, flag_q, id_q, mode_q};
				`REG_CTRL: rdata_d = ctrl_q;
				`REG_INDEX: rdata_d = idx_q;
				`REG_CDATA: rdata_d = cdata_q;
				`REG_RDIDX: rdata_d = rdidx_q;
				`REG_RDCTL: rdata_d = rdctl_q;
				`REG_PIXEL: rdata_d = {14'h0000, pix_q};
				`REG_PXCNT: rdata_d = {line_q, col_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			ack_q <= 1'b0;
			ctrl_q <= `CTRL_RESET;
			rdidx_q <= 32'h0000_0000;
			rdctl_q <= 32'h0000_0000;
			idx_q <= 32'h0000_0000;
			cdata_q <= 32'h0000_0000;
			flag_q <= 3'h0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			ctrl_q <= ctrl_d;
			rdidx_q <= rdidx_d;
			rdctl_q <= rdctl_d;
			idx_q <= idx_d;
			cdata_q <= cdata_d;
			flag_q <= flag_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata_o = rdata_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence store_close;
		is_par && sel && st_n_s && !st_n_q;
	endsequence

	AST_DESELECT: assert property (@(posedge clk_i) disable iff (core_rst)
		(sel_n_s && !is_ser) |-> !wr_evt && parallel_data_bus_oe_o == 18'h00000)
		else $error("access taken while deselected");
	AST_CAPTURE: assert property (@(posedge clk_i) disable iff (core_rst)
		store_close and (isel_s == 1'b1) |=> cdata_q[17:0] == $past(par_word))
		else $error("strobe write not captured into control data");
	AST_INDEX: assert property (@(posedge clk_i) disable iff (core_rst)
		store_close and (isel_s == 1'b0) |=> idx_q[17:0] == $past(par_word))
		else $error("index write not captured");
	AST_READ_DRIVE: assert property (@(posedge clk_i) disable iff (core_rst)
		(is_par && sel && !rd_n_s) |-> parallel_data_bus_oe_o == 18'h3FFFF)
		else $error("read strobe low but bus not driven");
	AST_P16_LANES: assert property (@(posedge clk_i) disable iff (core_rst)
		(store_close and (isel_s == 1'b0 && mode_q == MODE_P16))
		|=> idx_q[17:0] == {2'b00, $past(db_s[17:10]), $past(db_s[8:1])})
		else $error("16-bit lane mapping wrong");
	AST_STRAP: assert property (@(posedge clk_i) disable iff (core_rst)
		boot_q && strap_s[3:1] == 3'b010 |=> mode_q == MODE_SER && id_q == $past(strap_s[0]))
		else $error("serial strap not decoded");
	AST_INIT: assert property (@(posedge clk_i)
		!init_s |=> mode_q == MODE_NONE && flag_q == 3'h0 && !graphics_memory_we_o)
		else $error("init pin did not reset the logic");
	AST_INVALID_PX: assert property (@(posedge clk_i) disable iff (core_rst)
		!pvld_s || !pen_s |=> !graphics_memory_we_o)
		else $error("invalid pixel written");
	AST_BUS_ACK: assert property (@(posedge clk_i) disable iff (core_rst)
		$rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("bus answer not in one cycle");
endmodule : lcd_host_port

// >>> test/host_model.sv
/*
 * Host model: drives the strobe bus and the clocked serial link of the
 * panel port. Assumes clk_i is the bench clock and bus_i the resolved pins.
 */
`timescale 1ns/1ps

module host_model (
	input wire logic clk_i,
	input wire logic [17:0] bus_i,
	output logic select_n_o,
	output logic isel_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic [17:0] data_o
);
	initial begin
		select_n_o = 1'h1;
		isel_o = 1'h0;
		wr_n_o = 1'h1;
		rd_n_o = 1'h1;
		data_o = 18'h00000;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask : hold

	// ------------------------------------------------------------
	// strobe bus cycle
	// ------------------------------------------------------------
	// strobe cycle
	task automatic par_cycle(input logic sel, input logic isel, input logic rd,
			input logic [17:0] d, output logic [17:0] q);
		select_n_o <= ~sel;
		isel_o <= isel;
		data_o <= d;
		hold(1);
		if (rd) begin
			rd_n_o <= 1'h0;
		end else begin
			wr_n_o <= 1'h0;
		end
		hold(6);
		q = bus_i;
		rd_n_o <= 1'h1;
		wr_n_o <= 1'h1;
		// data and index select kept well past the rising strobe
		hold(5);
		select_n_o <= 1'h1;
		data_o <= {~d[17:9], d[8:0]};
		hold(1);
	endtask : par_cycle

	// ------------------------------------------------------------
	// serial frame
	// ------------------------------------------------------------
	// shift clock frame
	task automatic ser_frame(input logic [23:0] tx, output logic [15:0] rx);
		select_n_o <= 1'h0;
		hold(4);
		for (int i = 23; i >= 0; i--) begin
			wr_n_o <= 1'h0;
			data_o[0] <= tx[i];
			hold(4);
			wr_n_o <= 1'h1;
			hold(4);
			// sampled at the end of the high phase, just before the next fall
			rx = {rx[14:0], bus_i[1]};
		end
		select_n_o <= 1'h1;
		data_o[0] <= ~tx[0];
		hold(4);
	endtask : ser_frame
endmodule : host_model

// >>> test/tb_lcd_host_interface_select.sv
/*
 * Testbench of the panel host port: Avalon register tasks, strobe bus,
 * serial link and pixel port. Assumes the host model in host_model.sv.
 */
`timescale 1ns/1ps
`include "lcd_port_defines.svh"

module tb_lcd_host_interface_select;
	import lcd_port_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic [7:0] address = 8'h00;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, r;
	logic wait_req, init_n = 1'h1, init2_n = 1'h1, id = 1'h0, we;
	logic [2:0] straps = 3'h1;
	logic [17:0] pix = 18'h00000, host_d, dev_d, dev_oe, bus, q, wd;
	logic pclk = 1'h0, pen = 1'h0, pval = 1'h0, sel_n, isel, wr_n, rd_n;
	logic hs_n = 1'h1, vs_n = 1'h1;
	logic [15:0] sr;
	int n_fail = 0, n_tests = 0, cycles = 0, n_we = 0;
	bus_mode_t ms[4] = '{MODE_P16, MODE_P8, MODE_P18, MODE_P9};
	logic [3:0] ims[4] = '{4'h2, 4'h3, 4'hA, 4'hB};

	always #5 clk_i = ~clk_i;
	assign bus = (dev_oe & dev_d) | (~dev_oe & host_d);

	always @(posedge clk_i) begin
		cycles++;
		if (we === 1'h1) n_we++;
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	lcd_host_port lcd_host_port_i (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(address),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.hardware_init_n_i(init_n), .hardware_init2_n_i(init2_n),
		.interface_mode_straps_i(straps), .mode_or_code_strap_i(id),
		.select_n_i(sel_n), .register_index_select_i(isel), .store_strobe_n_i(wr_n),
		.read_strobe_n_i(rd_n), .parallel_data_bus_i(bus), .parallel_data_bus_o(dev_d),
		.parallel_data_bus_oe_o(dev_oe), .rgb_pixel_bus_i(pix), .pixel_clock_i(pclk),
		.pixel_enable_i(pen), .pixel_valid_i(pval), .line_sync_n_i(hs_n),
		.frame_sync_n_i(vs_n), .graphics_memory_we_o(we), .graphics_memory_wdata_o(wd));

	host_model host (.clk_i(clk_i), .bus_i(bus), .select_n_o(sel_n), .isel_o(isel),
		.wr_n_o(wr_n), .rd_n_o(rd_n), .data_o(host_d));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
		address <= a;
		wdata <= d;
		wr <= w;
		rd <= ~w;
		@(posedge clk_i);
		// only the cycle ceiling ends a wait that never finishes
		while (wait_req !== 1'h0) begin
			@(posedge clk_i);
		end
		r = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
		@(posedge clk_i);
	endtask : av

	task automatic boot(input logic [3:0] im);
		rst_i <= 1'h1;
		straps <= im[3:1];
		id <= im[0];
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (4) @(posedge clk_i);
	endtask : boot

	task automatic px(input logic en, input logic val, input logic [17:0] d);
		pen <= en;
		pval <= val;
		pix <= d;
		repeat (4) @(posedge clk_i);
		pclk <= 1'h1;
		repeat (4) @(posedge clk_i);
		pclk <= 1'h0;
		repeat (4) @(posedge clk_i);
	endtask : px

	function automatic logic [17:0] pack(input bus_mode_t m, input logic [17:0] w);
		case (m)
			MODE_P16: return {w[15:8], 1'h0, w[7:0], 1'h0};
			MODE_P8: return {w[7:0], 10'h000};
			MODE_P9: return {w[8:0], 9'h000};
			default: return w;
		endcase
	endfunction : pack

	function automatic logic [31:0] lane(input bus_mode_t m, input logic [17:0] b);
		case (m)
			MODE_P16: return {16'h0000, b[17:10], b[8:1]};
			MODE_P8: return {24'h000000, b[17:10]};
			MODE_P9: return {23'h000000, b[17:9]};
			default: return {14'h0000, b};
		endcase
	endfunction : lane

	task automatic give_verdict();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		boot(4'h2);
		av(0, `REG_CTRL, 32'h0);
		check("ctrl", 32'h1, r);
		av(0, 8'h20, 32'h0);
		check("unmapped", 32'h0, r);
		for (int k = 0; k < 4; k++) begin
			boot(ims[k]);
			av(0, `REG_STATUS, 32'h0);
			check("mode", 32'(ms[k]), {29'h0, r[2:0]});
			host.par_cycle(1, 0, 0, pack(ms[k], 18'h2A5C3), q);
			host.par_cycle(1, 1, 0, pack(ms[k], 18'h1B7E1), q);
			host.par_cycle(0, 0, 0, pack(ms[k], 18'h3FFFF), q);
			av(0, `REG_INDEX, 32'h0);
			check("index", lane(ms[k], pack(ms[k], 18'h2A5C3)), r);
			av(0, `REG_CDATA, 32'h0);
			check("cdata", lane(ms[k], pack(ms[k], 18'h1B7E1)), r);
			av(0, `REG_STATUS, 32'h0);
			check("wr flag", 32'h10, r & 32'h10);
			av(1, `REG_STATUS, 32'h10);
			av(0, `REG_STATUS, 32'h0);
			check("wr flag clr", 32'h0, r & 32'h10);
			av(1, `REG_RDIDX, 32'h1E1E1);
			av(1, `REG_RDCTL, 32'h2D2B4);
			host.par_cycle(1, 0, 1, 18'h00000, q);
			check("read idx", lane(ms[k], pack(ms[k], 18'h1E1E1)), lane(ms[k], q));
			host.par_cycle(1, 1, 1, 18'h00000, q);
			check("read ctl", lane(ms[k], pack(ms[k], 18'h2D2B4)), lane(ms[k], q));
		end
		boot(4'h0);
		av(0, `REG_STATUS, 32'h0);
		check("bad strap", 32'h80, r & 32'h87);
		host.par_cycle(1, 0, 0, 18'h3FFFF, q);
		av(0, `REG_INDEX, 32'h0);
		check("no mode idx", 32'h0, r);
		boot(4'h5);
		av(0, `REG_STATUS, 32'h0);
		check("serial id", 32'hD, r & 32'hF);
		host.ser_frame({5'h0E, 3'h4, 16'hBEEF}, sr);
		host.ser_frame({5'h0E, 3'h0, 16'h1234}, sr);
		av(0, `REG_INDEX, 32'h0);
		check("ser index", 32'hBEEF, r);
		av(1, `REG_RDCTL, 32'h5AC3);
		host.ser_frame({5'h0E, 3'h7, 16'h0000}, sr);
		check("ser read", 32'h5AC3, {16'h0000, sr});
		px(1, 1, 18'h3C0F3);
		px(1, 0, 18'h00F0F);
		px(0, 1, 18'h0F0F0);
		av(0, `REG_PIXEL, 32'h0);
		check("pixel", 32'h3C0F3, r);
		check("wdata", 32'h3C0F3, {14'h0000, wd});
		av(1, `REG_CTRL, 32'h0);
		px(1, 1, 18'h11111);
		check("we count", 32'h1, 32'(n_we));
		av(0, `REG_PXCNT, 32'h0);
		check("pxcnt", 32'h0000_0001, r);
		hs_n <= 1'h0;
		repeat (4) @(posedge clk_i);
		hs_n <= 1'h1;
		av(0, `REG_PXCNT, 32'h0);
		check("line", 32'h0001_0000, r);
		vs_n <= 1'h0;
		repeat (4) @(posedge clk_i);
		vs_n <= 1'h1;
		av(0, `REG_PXCNT, 32'h0);
		check("frame", 32'h0000_0000, r);
		for (int j = 0; j < 2; j++) begin
			av(1, `REG_CTRL, 32'h0);
			if (j == 0) begin
				init_n <= 1'h0;
			end else begin
				init2_n <= 1'h0;
			end
			repeat (6) @(posedge clk_i);
			init_n <= 1'h1;
			init2_n <= 1'h1;
			repeat (6) @(posedge clk_i);
			av(0, `REG_CTRL, 32'h0);
			check("init ctrl", 32'h1, r);
		end
		give_verdict();
	end
endmodule : tb_lcd_host_interface_select
